// ===== art_pkg.sv
// Constants shared by the auto-reload PWM timer.
// Assumes a 32-bit AXI4-Lite bus with byte addresses of four times index.
package art_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DUTY3   = 6'h31;
  localparam logic [5:0] IDX_DUTY2   = 6'h32;
  localparam logic [5:0] IDX_DUTY1   = 6'h33;
  localparam logic [5:0] IDX_DUTY0   = 6'h34;
  localparam logic [5:0] IDX_PWMCTL  = 6'h35;
  localparam logic [5:0] IDX_CTLSTAT = 6'h36;
  localparam logic [5:0] IDX_CNT     = 6'h37;
  localparam logic [5:0] IDX_RELOAD  = 6'h38;
  localparam logic [5:0] IDX_CAPCTL  = 6'h39;
  localparam logic [5:0] IDX_CAP1    = 6'h3a;
  localparam logic [5:0] IDX_CAP2    = 6'h3b;

  // ----------------------------------------------------------------
  // Field positions of timer_ctrl_status
  // ----------------------------------------------------------------
  localparam int BIT_EXTCLK  = 7;
  localparam int BIT_PSC_HI  = 6;
  localparam int BIT_PSC_LO  = 4;
  localparam int BIT_RUN     = 3;
  localparam int BIT_FRELOAD = 2;
  localparam int BIT_OVFIE   = 1;

  // ----------------------------------------------------------------
  // Field positions of pwm_output_control and capture_ctrl_status
  // ----------------------------------------------------------------
  localparam int BIT_OE_LO   = 4;
  localparam int BIT_EDGE_LO = 4;
  localparam int BIT_CIE_LO  = 2;

  // ----------------------------------------------------------------
  // Widths, reset values and bus answers
  // ----------------------------------------------------------------
  localparam int         DW       = 8;
  localparam int         PSC_W    = 7;
  localparam int         AXI_AW   = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hff;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

endpackage

// ===== art_pwm_timer.sv
// Eight-bit auto-reload timer with four PWM outputs, two captures.
// Assumes haltMode comes from logic on the same clock; pins are async.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module art_pwm_timer #(
  parameter int N_PWM = 4,
  parameter int N_CAP = 2
) (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // AXI4-Lite slave
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [art_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [art_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // Pins and system
  input  wire logic                      haltMode,
  input  wire logic                      extClockPin,
  input  wire logic [N_CAP-1:0]          captureInputPin,
  output logic [N_PWM-1:0]               pwmOutputPin,
  output logic [N_PWM-1:0]               pwmOutputPinOe,
  output logic                           overflowIrq,
  output logic [N_CAP-1:0]               captureIrq
);
  import art_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Word aligned and inside the printed index range
  function automatic logic isMapped(input logic [AXI_AW-1:0] a);
    isMapped = (a[1:0] == 2'h0) && (a[7:2] >= IDX_DUTY3)
               && (a[7:2] <= IDX_CAP2);
  endfunction

  // Duty register index for a channel
  function automatic logic [5:0] dutyIdx(input int ch);
    dutyIdx = IDX_DUTY0 - 6'(ch);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic             awHeld_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic             wHeld_ff;
  logic [DW-1:0]    wData_ff;
  logic             wStrb_ff;
  logic             bValid_ff;
  logic [1:0]       bResp_ff;
  logic             rValid_ff;
  logic [31:0]      rData_ff;
  logic [1:0]       rResp_ff;

  logic             extClkSel_ff;
  logic [2:0]       prescaleSel_ff;
  logic             countRun_ff;
  logic             ovfIrqEn_ff;
  logic             overflowFlag_ff;
  logic [DW-1:0]    reload_ff;
  logic [DW-1:0]    count_ff;
  logic [PSC_W-1:0] presc_ff;
  logic [N_PWM-1:0] pinEnable_ff;
  logic [N_PWM-1:0] polarity_ff;
  logic [N_CAP-1:0] edgeSel_ff;
  logic [N_CAP-1:0] capIrqEn_ff;
  logic [N_CAP-1:0] captureFlags_ff;
  logic             extSync1_ff;
  logic             extSync2_ff;
  logic             extPrev_ff;

  logic [DW-1:0]    duty_ff   [N_PWM];
  logic [DW-1:0]    shadow_ff [N_PWM];
  logic [DW-1:0]    capVal_ff [N_CAP];

  // ----------------------------------------------------------------
  // Bus handshakes and decode
  // ----------------------------------------------------------------
  // One address and one data slot; either may arrive first
  logic       doWrite;
  logic       rdHs;
  logic [5:0] wIdx;
  logic [5:0] rIdx;
  logic       wHit;
  logic       rHit;
  logic       wrOn;

  assign s_axi_awready = !awHeld_ff;
  assign s_axi_wready  = !wHeld_ff;
  assign doWrite       = awHeld_ff && wHeld_ff && !bValid_ff;
  assign wIdx          = awAddr_ff[7:2];
  assign wHit          = isMapped(awAddr_ff);
  assign wrOn          = doWrite && wHit && wStrb_ff;
  assign s_axi_arready = !rValid_ff;
  assign rdHs          = s_axi_arvalid && !rValid_ff;
  assign rIdx          = s_axi_araddr[7:2];
  assign rHit          = isMapped(s_axi_araddr);
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;

  // Register strobes, low byte lane only
  logic wrCtl;
  logic wrCnt;
  logic wrReload;
  logic wrPwmCtl;
  logic wrCapCtl;
  logic forceLoad;
  logic rdCtl;

  assign wrCtl     = wrOn && (wIdx == IDX_CTLSTAT);
  assign wrCnt     = wrOn && (wIdx == IDX_CNT);
  assign wrReload  = wrOn && (wIdx == IDX_RELOAD);
  assign wrPwmCtl  = wrOn && (wIdx == IDX_PWMCTL);
  assign wrCapCtl  = wrOn && (wIdx == IDX_CAPCTL);
  assign forceLoad = wrCtl && wData_ff[BIT_FRELOAD];
  assign rdCtl     = rdHs && rHit && (rIdx == IDX_CTLSTAT);

  // Address and data slots
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff  <= 1'b0;
      wData_ff  <= RST_BYTE;
      wStrb_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && !awHeld_ff) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_ff) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata[DW-1:0];
        wStrb_ff <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bValid_ff <= 1'b0;
      bResp_ff  <= RESP_OK;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff  <= wHit ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [DW-1:0] ctlRead;
  logic [DW-1:0] pwmCtlRead;
  logic [DW-1:0] capCtlRead;
  logic [DW-1:0] rdMux;

  // Force reload bit always reads zero
  assign ctlRead = {extClkSel_ff, prescaleSel_ff, countRun_ff, 1'b0,
                    ovfIrqEn_ff, overflowFlag_ff};
  assign pwmCtlRead = {pinEnable_ff, polarity_ff};
  // Reserved top bits read zero
  assign capCtlRead = {2'h0, edgeSel_ff, capIrqEn_ff, captureFlags_ff};

  always_comb begin
    rdMux = RST_BYTE;
    unique case (rIdx)
      IDX_DUTY3:   rdMux = duty_ff[3];
      IDX_DUTY2:   rdMux = duty_ff[2];
      IDX_DUTY1:   rdMux = duty_ff[1];
      IDX_DUTY0:   rdMux = duty_ff[0];
      IDX_PWMCTL:  rdMux = pwmCtlRead;
      IDX_CTLSTAT: rdMux = ctlRead;
      IDX_CNT:     rdMux = count_ff;
      IDX_RELOAD:  rdMux = reload_ff;
      IDX_CAPCTL:  rdMux = capCtlRead;
      IDX_CAP1:    rdMux = capVal_ff[0];
      IDX_CAP2:    rdMux = capVal_ff[1];
      default:     rdMux = RST_BYTE;
    endcase
  end

  // Read data registered; side effects fire at the address handshake
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rValid_ff <= 1'b0;
      rData_ff  <= '0;
      rResp_ff  <= RESP_OK;
    end else if (rdHs) begin
      rValid_ff <= 1'b1;
      rData_ff  <= rHit ? {24'h0, rdMux} : 32'h0;
      rResp_ff  <= rHit ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      extClkSel_ff   <= 1'b0;
      prescaleSel_ff <= 3'h0;
      countRun_ff    <= 1'b0;
      ovfIrqEn_ff    <= 1'b0;
      reload_ff      <= RST_BYTE;
      pinEnable_ff   <= '0;
      polarity_ff    <= '0;
      edgeSel_ff     <= '0;
      capIrqEn_ff    <= '0;
    end else begin
      if (wrCtl) begin
        extClkSel_ff   <= wData_ff[BIT_EXTCLK];
        prescaleSel_ff <= wData_ff[BIT_PSC_HI:BIT_PSC_LO];
        countRun_ff    <= wData_ff[BIT_RUN];
        ovfIrqEn_ff    <= wData_ff[BIT_OVFIE];
      end
      if (wrReload) begin
        reload_ff <= wData_ff;
      end
      if (wrPwmCtl) begin
        pinEnable_ff <= wData_ff[BIT_OE_LO +: N_PWM];
        polarity_ff  <= wData_ff[N_PWM-1:0];
      end
      if (wrCapCtl) begin
        edgeSel_ff  <= wData_ff[BIT_EDGE_LO +: N_CAP];
        capIrqEn_ff <= wData_ff[BIT_CIE_LO +: N_CAP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler input: CPU clock or synchronised external clock
  // ----------------------------------------------------------------
  // Two stages before the edge detector; the ext clock is a pin
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      extSync1_ff <= 1'b0;
      extSync2_ff <= 1'b0;
      extPrev_ff  <= 1'b0;
    end else begin
      extSync1_ff <= extClockPin;
      extSync2_ff <= extSync1_ff;
      extPrev_ff  <= extSync2_ff;
    end
  end

  logic             inTick;
  logic [PSC_W-1:0] tapMask;
  logic             cntTick;
  logic             overflow;

  // Rising edge of the ext clock, else every CPU cycle
  assign inTick  = extClkSel_ff ? (extSync2_ff && !extPrev_ff) : 1'b1;
  // Low prescaler bits all ones select tap 2^n
  assign tapMask = PSC_W'((8'h01 << prescaleSel_ff) - 8'h01);
  // Nothing advances while run enable is low
  assign cntTick = countRun_ff && inTick
                   && ((presc_ff & tapMask) == tapMask);
  // Software write or force reload suppresses the overflow
  assign overflow = cntTick && (count_ff == CNT_MAX)
                    && !wrCnt && !forceLoad;

  // Prescaler; a counter write or force reload restarts its phase
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      presc_ff <= '0;
    end else if (wrCnt || forceLoad) begin
      presc_ff <= '0;
    end else if (countRun_ff && inTick) begin
      presc_ff <= presc_ff + PSC_W'(1);
    end
  end

  // Counter; software write first, then force reload, then counting
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= RST_BYTE;
    end else if (wrCnt) begin
      count_ff <= wData_ff;
    end else if (forceLoad) begin
      count_ff <= reload_ff;
    end else if (overflow) begin
      count_ff <= reload_ff;
    end else if (cntTick) begin
      count_ff <= count_ff + DW'(1);
    end
  end

  // Overflow flag; a set in the read cycle wins over the clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overflowFlag_ff <= 1'b0;
    end else if (overflow) begin
      overflowFlag_ff <= 1'b1;
    end else if (rdCtl) begin
      overflowFlag_ff <= 1'b0;
    end
  end

  assign overflowIrq = overflowFlag_ff && ovfIrqEn_ff;

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < N_PWM; gp++) begin : gPwm
      logic wrDuty;
      logic belowCmp;
      logic pwmLevel;

      assign wrDuty = wrOn && (wIdx == dutyIdx(gp));
      // Level true from reload until the count passes compare
      assign belowCmp = (count_ff <= shadow_ff[gp]);
      // Polarity applied on the live level, no wait
      assign pwmLevel = belowCmp ^ polarity_ff[gp];

      // Duty register and its hidden compare copy
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          duty_ff[gp]   <= RST_BYTE;
          shadow_ff[gp] <= RST_BYTE;
        end else begin
          if (wrDuty) begin
            duty_ff[gp] <= wData_ff;
          end
          // Only at overflow so a duty change cannot glitch
          if (overflow) begin
            shadow_ff[gp] <= duty_ff[gp];
          end
        end
      end

      // Output flop; reload count is at or below compare
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pwmOutputPin[gp] <= 1'b0;
        end else begin
          pwmOutputPin[gp] <= pinEnable_ff[gp] && pwmLevel;
        end
      end
    end
  endgenerate

  // Pin driven only while its enable bit is set
  assign pwmOutputPinOe = pinEnable_ff;

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  genvar gc;
  generate
    for (gc = 0; gc < N_CAP; gc++) begin : gCap
      logic sync1_ff;
      logic sync2_ff;
      logic prev_ff;
      logic edgeHit;
      logic capture;
      logic rdCap;
      logic haltWake;

      // Two stages; the first feeds only the second
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_ff <= 1'b0;
          sync2_ff <= 1'b0;
          prev_ff  <= 1'b0;
        end else begin
          sync1_ff <= captureInputPin[gc];
          sync2_ff <= sync1_ff;
          prev_ff  <= sync2_ff;
        end
      end

      // 1 selects rising, 0 falling
      assign edgeHit = edgeSel_ff[gc] ? (sync2_ff && !prev_ff)
                                      : (!sync2_ff && prev_ff);
      assign rdCap = rdHs && rHit && (rIdx == IDX_CAP1 + 6'(gc));
      // Blocked while the flag stands, unless read this cycle
      assign capture = edgeHit && !haltMode
                       && (!captureFlags_ff[gc] || rdCap);

      // Captured value is read-only; bus writes never reach it
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          capVal_ff[gc] <= RST_BYTE;
        end else if (capture) begin
          capVal_ff[gc] <= count_ff;
        end
      end

      // Capture flag; a capture in the read cycle wins
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          captureFlags_ff[gc] <= 1'b0;
        end else if (capture) begin
          captureFlags_ff[gc] <= 1'b1;
        end else if (rdCap) begin
          captureFlags_ff[gc] <= 1'b0;
        end
      end

      // Clock may be stopped in halt: raw pin at the active level
      // requests straight away, no flop in the path
      assign haltWake = haltMode
                        && (captureInputPin[gc] == edgeSel_ff[gc]);
      // Edge-flagged request doubles as external interrupt
      assign captureIrq[gc] = capIrqEn_ff[gc]
                              && (captureFlags_ff[gc] || haltWake);
    end
  endgenerate

endmodule

`default_nettype wire

// ===== art_sva.sv
// Port assertions for the auto-reload PWM timer.
// Assumes it is bound to art_pwm_timer and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module art_sva_chk #(
  parameter int N_PWM = 4,
  parameter int N_CAP = 2
) (
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             haltMode,
  input wire logic [N_PWM-1:0] pwmOutputPin,
  input wire logic [N_PWM-1:0] pwmOutputPinOe,
  input wire logic             overflowIrq,
  input wire logic [N_CAP-1:0] captureIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Pin quiet once its enable has been low for two samples
  a_oe_gates_pin: assert property (
    (pwmOutputPin & ~pwmOutputPinOe & ~$past(pwmOutputPinOe)) == '0)
    else $error("pwm pin driven while disabled");
  a_oe_by_write: assert property (
    !$stable(pwmOutputPinOe) |-> s_axi_bvalid)
    else $error("output enables moved without a write");
  // Outside halt, requests drop only after a read or a write
  a_ovf_clear: assert property (
    $fell(overflowIrq) |->
      s_axi_bvalid || $past(s_axi_arvalid && s_axi_arready))
    else $error("overflow request dropped by itself");
  a_cap_clear: assert property (
    $fell(captureIrq[0]) && !haltMode && !$past(haltMode) |->
      s_axi_bvalid || $past(s_axi_arvalid && s_axi_arready))
    else $error("capture request dropped by itself");
  // Bus answers at the promised distance, upper bytes zero, no new read address during an answer
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data beyond the byte lane");
  a_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");

  c_ovf: cover property ($rose(overflowIrq));
  c_cap: cover property ($rose(captureIrq[0]));
  c_pwm: cover property ($rose(pwmOutputPin[1]));
endmodule

bind art_pwm_timer art_sva_chk #(.N_PWM(N_PWM), .N_CAP(N_CAP)) chk_u (
  .clock(clock), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .haltMode(haltMode), .pwmOutputPin(pwmOutputPin),
  .pwmOutputPinOe(pwmOutputPinOe), .overflowIrq(overflowIrq),
  .captureIrq(captureIrq));
`default_nettype wire

// ===== art_pin_model.sv
// Far-side model: capture signal sources and an external event clock.
// Assumes the bench sets levels and bursts; pins are async to clock.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Pin sources
// ----------------------------------------------------------------
module art_pin_model #(
  parameter int HALF_NS = 370,
  parameter int LAG_NS  = 230
) (
  input  wire logic       extGo,
  input  wire logic [7:0] extCount,
  input  wire logic [1:0] capTarget,
  output logic            extClockPin,
  output logic [1:0]      captureInputPin
);
  int n;
  initial extClockPin = 1'b0;
  initial captureInputPin = 2'b00;
  // Late source, so edges land between clock edges
  always @(capTarget) captureInputPin <= #(LAG_NS) capTarget;
  // Event clock stands low outside a burst
  always @(posedge extGo) begin
    for (n = 0; n < int'(extCount); n++) begin
      #(HALF_NS) extClockPin = 1'b1;
      #(HALF_NS) extClockPin = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== art_tb.sv
// Register-level bench for the auto-reload PWM timer.
// Assumes art_pkg, the checker bind and the pin model are compiled first.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module testbench;
  import art_pkg::*;
  logic clock, sys_rst, haltMode, extGo, extClk;
  logic awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady;
  logic [7:0] awAddr, arAddr, extCount, d, c0;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp, r, capTarget, capPin, capIrq;
  logic [3:0] pwmPin, pwmOe;
  logic ovfIrq;
  int fails, totalChecks, i, df;

  art_pwm_timer dut_u (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'h1), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .haltMode(haltMode),
    .extClockPin(extClk), .captureInputPin(capPin), .pwmOutputPin(pwmPin),
    .pwmOutputPinOe(pwmOe), .overflowIrq(ovfIrq), .captureIrq(capIrq));
  art_pin_model pin_u (.extGo(extGo), .extCount(extCount),
    .capTarget(capTarget), .extClockPin(extClk), .captureInputPin(capPin));

  // Verdict and shared comparison
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic checkVal(input string nm, input logic [7:0] s, e);
    totalChecks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus cycles; a used-up bound ends the run as a failure
  task automatic wrChk(input logic [5:0] ix, input logic [7:0] v,
                       input logic [1:0] er);
    int n;
    bit done;
    done = 1'b0;
    awAddr <= {ix, 2'b00};
    wData <= {24'h0, v};
    awValid <= 1'b1;
    wValid <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        done = 1'b1;
        checkVal("bresp", {6'h0, bResp}, {6'h0, er});
      end
    end
    @(posedge clock);
    if (!done) begin
      fails++;
      finishTest();
    end
  endtask
  task automatic axiRd(input logic [5:0] ix, output logic [7:0] v,
                       output logic [1:0] rs);
    int n;
    bit done;
    done = 1'b0;
    arAddr <= {ix, 2'b00};
    arValid <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        done = 1'b1;
        v = rData[7:0];
        rs = rResp;
      end
    end
    if (!done) begin
      fails++;
      finishTest();
    end
  endtask
  task automatic rdChk(input logic [5:0] ix, input logic [7:0] e,
                       input logic [1:0] er = RESP_OK);
    logic [7:0] v;
    logic [1:0] rs;
    axiRd(ix, v, rs);
    checkVal($sformatf("reg %h", ix), v, e);
    checkVal("rresp", {6'h0, rs}, {6'h0, er});
  endtask

  // Free-running 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Main sequence
  initial begin
    {sys_rst, haltMode, extGo, awValid, wValid, bReady, rReady} = 7'h43;
    {arValid, awAddr, arAddr, wData, extCount, capTarget} = '0;
    fails = 0;
    totalChecks = 0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 11; i++) rdChk(6'(IDX_DUTY3 + i), RST_BYTE);
    rdChk(6'h30, 8'h00, RESP_ERR);
    wrChk(6'h3c, 8'h5a, RESP_ERR);
    for (i = 0; i < 4; i++)
      wrChk(6'(IDX_DUTY3 + i), 8'(15 - 4*i), RESP_OK);
    for (i = 0; i < 4; i++) rdChk(6'(IDX_DUTY3 + i), 8'(15 - 4*i));
    wrChk(IDX_RELOAD, 8'hfe, RESP_OK);
    wrChk(IDX_CNT, 8'hfd, RESP_OK);
    wrChk(IDX_PWMCTL, 8'hf0, RESP_OK);
    wrChk(IDX_CTLSTAT, 8'h0a, RESP_OK);
    repeat (4) @(posedge clock);
    checkVal("ovf irq", {7'h0, ovfIrq}, 8'h01);
    wrChk(IDX_CTLSTAT, 8'h02, RESP_OK);
    rdChk(IDX_CTLSTAT, 8'h03);
    checkVal("ovf irq", {7'h0, ovfIrq}, 8'h00);
    rdChk(IDX_CTLSTAT, 8'h02);
    wrChk(IDX_CTLSTAT, 8'h08, RESP_OK);
    repeat (4) @(posedge clock);
    checkVal("masked irq", {7'h0, ovfIrq}, 8'h00);
    wrChk(IDX_CTLSTAT, 8'h00, RESP_OK);
    rdChk(IDX_CTLSTAT, 8'h01);
    axiRd(IDX_CNT, c0, r);
    checkVal("reloaded", {7'h0, c0 >= 8'hfe}, 8'h01);
    rdChk(IDX_CNT, c0);
    // Compare shadows hold 3,7,11,15 now; polarity, enable, no glitch
    wrChk(IDX_CNT, 8'h06, RESP_OK);
    checkVal("pwm", {4'h0, pwmPin}, 8'h0e);
    wrChk(IDX_PWMCTL, 8'hff, RESP_OK);
    checkVal("pwm pol", {4'h0, pwmPin}, 8'h01);
    wrChk(IDX_DUTY0, 8'h08, RESP_OK);
    checkVal("pwm shadow", {4'h0, pwmPin}, 8'h01);
    wrChk(IDX_PWMCTL, 8'ha0, RESP_OK);
    checkVal("pwm oe", {pwmOe, pwmPin}, 8'haa);
    wrChk(IDX_RELOAD, 8'h40, RESP_OK);
    wrChk(IDX_CTLSTAT, 8'h04, RESP_OK);
    rdChk(IDX_CNT, 8'h40);
    rdChk(IDX_CTLSTAT, 8'h00);
    // Every divider code against the undivided count
    for (i = 0; i < 8; i++) begin
      wrChk(IDX_CNT, 8'h00, RESP_OK);
      wrChk(IDX_CTLSTAT, 8'(8 + 16*i), RESP_OK);
      repeat (100) @(posedge clock);
      wrChk(IDX_CTLSTAT, 8'h00, RESP_OK);
      axiRd(IDX_CNT, d, r);
      if (i == 0) c0 = d;
      df = int'(d) - int'(c0 >> i);
      checkVal("prescale", {7'h0, df >= -1 && df <= 1}, 8'h01);
    end
    wrChk(IDX_CNT, 8'h00, RESP_OK);
    wrChk(IDX_CTLSTAT, 8'h88, RESP_OK);
    extCount <= 8'd5;
    extGo <= 1'b1;
    repeat (50) @(posedge clock);
    extGo <= 1'b0;
    wrChk(IDX_CTLSTAT, 8'h00, RESP_OK);
    rdChk(IDX_CNT, 8'h05);
    // Captures: rising on channel one, blocked until read
    wrChk(IDX_CNT, 8'h33, RESP_OK);
    wrChk(IDX_CAPCTL, 8'h14, RESP_OK);
    capTarget <= 2'b01;
    repeat (10) @(posedge clock);
    checkVal("cap irq", {6'h0, capIrq}, 8'h01);
    rdChk(IDX_CAPCTL, 8'h15);
    wrChk(IDX_CNT, 8'h44, RESP_OK);
    capTarget <= 2'b00;
    repeat (10) @(posedge clock);
    capTarget <= 2'b11;
    repeat (10) @(posedge clock);
    rdChk(IDX_CAP1, 8'h33);
    rdChk(IDX_CAPCTL, 8'h14);
    wrChk(IDX_CAP1, 8'h99, RESP_OK);
    rdChk(IDX_CAP1, 8'h33);
    wrChk(IDX_CAPCTL, 8'h1c, RESP_OK);
    checkVal("cap quiet", {6'h0, capIrq}, 8'h00);
    capTarget <= 2'b01;
    repeat (10) @(posedge clock);
    checkVal("cap fall", {6'h0, capIrq}, 8'h02);
    rdChk(IDX_CAP2, 8'h44);
    // Halt: wake request straight from the pin, no capture taken
    capTarget <= 2'b00;
    repeat (10) @(posedge clock);
    haltMode <= 1'b1;
    @(posedge clock);
    checkVal("halt idle", {7'h0, capIrq[0]}, 8'h00);
    capTarget <= 2'b01;
    #260;
    checkVal("halt wake", {7'h0, capIrq[0]}, 8'h01);
    repeat (4) @(posedge clock);
    haltMode <= 1'b0;
    repeat (3) @(posedge clock);
    rdChk(IDX_CAPCTL, 8'h1c);
    finishTest();
  end
endmodule
`default_nettype wire
